// ===== hdl/bmd_decoder.sv
`timescale 1ns/1ps
// What this block does
// - Enable open: power stage off, motor coasts
// - Forward open with forward command: decelerate
// - Reverse open with reverse command: decelerate
// - Both permissives open: decelerate to stop
// - Homing closed: drive forward to marker
// - Command-type closed torque, open speed
// - Torque-mode stop: zero current, no hold
// - Select inputs map to tables one-four
// - Fault-reset closure clears latched fault
// - Enabled external trip: open input trips
// - Trip input ignored unless trip enabled
// - Mode writes rejected while drive enabled
// - Operating mode kept outside the tables
// - Parameter edits hit selected table only
// - Active-table parameter: 0 means table one
// - Non-switching table mode freezes selection
module bmd_decoder
  import bmd_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned NUM_PARAMS = 4
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Discrete control pins, high means contact closed
  input wire logic enable_i,
  input wire logic fwd_perm_i,
  input wire logic rev_perm_i,
  input wire logic home_i,
  input wire logic torque_sel_i,
  input wire logic table_sel0_i,
  input wire logic table_sel1_i,
  input wire logic fault_reset_i,
  input wire logic ext_trip_i,
  // Run commands from the command source
  input wire logic fwd_cmd_i,
  input wire logic rev_cmd_i,
  input wire logic home_done_i,
  input wire logic fault_set_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Drive control outputs
  output logic power_en_o,
  output logic run_fwd_o,
  output logic run_rev_o,
  output logic decel_o,
  output logic homing_o,
  output logic torque_mode_o,
  output logic zero_current_o,
  output logic hold_zero_speed_o,
  output logic [1:0] table_o,
  output logic fault_o,
  output logic ext_trip_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int unsigned CW = $clog2(DEBOUNCE_CYCLES + 1);

  typedef struct packed {
    logic [NUM_IN-1:0] s1;
    logic [NUM_IN-1:0] s2;
    logic [NUM_IN-1:0] db;
    logic [NUM_IN-1:0][CW-1:0] cnt;
    logic freset_prev;
    logic [1:0] table_sel;
    logic [MODE_W-1:0] op_mode;
    logic [NUM_TABLES-1:0][NUM_PARAMS-1:0][PARAM_W-1:0] params;
    logic [3:0] param_idx;
    logic trip_en;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [15:0] rdata;
    logic power_en;
    logic run_fwd;
    logic run_rev;
    logic decel;
    logic homing;
    logic torque;
    logic zero_cur;
    logic hold_zero;
    logic fault;
    logic ext_trip;
    logic irq;
  } bmd_state_t;

  bmd_state_t q, d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] pins;
  logic [NUM_IN-1:0] db_next;
  logic [NUM_IN-1:0][CW-1:0] cnt_next;
  assign pins = {ext_trip_i, fault_reset_i, table_sel1_i, table_sel0_i, torque_sel_i,
                 home_i, rev_perm_i, fwd_perm_i, enable_i};

  // Each pin must hold a new level for the full window before it counts
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_db
      always_comb begin
        db_next[gi] = q.db[gi];
        cnt_next[gi] = '0;
        if (q.s2[gi] != q.db[gi]) begin
          if (q.cnt[gi] >= CW'(DEBOUNCE_CYCLES - 1)) begin
            db_next[gi] = q.s2[gi];
          end else begin
            cnt_next[gi] = q.cnt[gi] + CW'(1);
          end
        end
      end
    end
  endgenerate

  function automatic logic mode_switchable(input logic [MODE_W-1:0] m);
    return (m == MODE_BIPOLAR) || (m == MODE_PROCESS) || (m == MODE_NETWORK);
  endfunction

  logic en, fwd_ok, rev_ok, freset_pulse, trip_evt, drive_on, stop_req;
  logic [1:0] sel_req;

  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.db = db_next;
    d.cnt = cnt_next;
    en = q.db[IN_ENABLE];
    fwd_ok = q.db[IN_FWD];
    rev_ok = q.db[IN_REV];
    freset_pulse = q.db[IN_FRESET] & ~q.freset_prev;
    d.freset_prev = q.db[IN_FRESET];
    sel_req = {q.db[IN_SEL1], q.db[IN_SEL0]};
    drive_on = en;

    // Table switching only while the operating mode allows it
    if (sel_req != q.table_sel && mode_switchable(q.op_mode)) begin
      d.table_sel = sel_req;
      d.op_mode = q.op_mode;
      d.irq_stat[IRQ_TBL_CHG] = 1'b1;
    end

    trip_evt = q.trip_en & ~q.db[IN_TRIP];
    d.power_en = en;
    d.torque = q.db[IN_TORQUE];
    d.homing = en & q.db[IN_HOME] & ~home_done_i & fwd_ok;
    d.run_fwd = en & ~q.fault & (fwd_cmd_i | d.homing) & fwd_ok;
    d.run_rev = en & ~q.fault & rev_cmd_i & ~d.homing & rev_ok;
    stop_req = (fwd_cmd_i & ~fwd_ok) | (rev_cmd_i & ~rev_ok) | (~fwd_ok & ~rev_ok);
    d.decel = en & stop_req & ~d.run_fwd & ~d.run_rev;
    // Torque mode stop releases the shaft rather than holding zero speed
    d.zero_cur = en & q.db[IN_TORQUE] & ~d.run_fwd & ~d.run_rev;
    d.hold_zero = en & ~q.db[IN_TORQUE] & ~d.run_fwd & ~d.run_rev & ~d.decel;

    // Fault latch: a new fault beats the reset closure
    if (freset_pulse) begin
      d.fault = 1'b0;
      d.ext_trip = 1'b0;
      d.irq_stat[IRQ_FAULT_CLR] = 1'b1;
    end
    if (trip_evt) begin
      d.ext_trip = 1'b1;
    end
    if (trip_evt | fault_set_i) begin
      d.fault = 1'b1;
    end
    if (trip_evt & ~q.ext_trip) begin
      d.irq_stat[IRQ_EXT_TRIP] = 1'b1;
    end

    // Register port
    d.rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL: d.rdata = {15'h0000, q.trip_en};
        REG_STATUS: d.rdata = {8'h00, q.fault, q.ext_trip, q.torque, q.homing,
                               q.decel, q.run_rev, q.run_fwd, q.power_en};
        REG_IRQ_STAT: d.rdata = {12'h000, q.irq_stat};
        REG_IRQ_MASK: d.rdata = {12'h000, q.irq_mask};
        REG_MODE: d.rdata = {12'h000, q.op_mode};
        REG_PARAM: d.rdata = q.params[q.table_sel][q.param_idx[1:0]];
        REG_ACT_TBL: d.rdata = {14'h0000, q.table_sel};
        default: d.rdata = '0;
      endcase
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_CTRL: d.trip_en = reg_wdata_i[CTRL_EXT_TRIP_EN];
        REG_IRQ_STAT: d.irq_stat = d.irq_stat & ~(q.irq_stat & reg_wdata_i[IRQ_W-1:0]);
        REG_IRQ_MASK: d.irq_mask = reg_wdata_i[IRQ_W-1:0];
        REG_MODE: begin
          if (drive_on) begin
            d.irq_stat[IRQ_MODE_REJ] = 1'b1;
          end else begin
            d.op_mode = reg_wdata_i[MODE_W-1:0];
          end
        end
        REG_PARAM: d.params[q.table_sel][q.param_idx[1:0]] = reg_wdata_i;
        REG_ACT_TBL: d.param_idx = reg_wdata_i[3:0];
        default: ;
      endcase
    end
    // Sets raised this cycle survive the clear written in the same cycle
    if (freset_pulse) d.irq_stat[IRQ_FAULT_CLR] = 1'b1;
    if (trip_evt & ~q.ext_trip) d.irq_stat[IRQ_EXT_TRIP] = 1'b1;
    if (reg_wr_i && reg_addr_i == REG_MODE && drive_on) d.irq_stat[IRQ_MODE_REJ] = 1'b1;
    if (sel_req != q.table_sel && mode_switchable(q.op_mode)) d.irq_stat[IRQ_TBL_CHG] = 1'b1;
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.op_mode <= MODE_RST;
      q.table_sel <= TABLE_ONE;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign power_en_o = q.power_en;
  assign run_fwd_o = q.run_fwd;
  assign run_rev_o = q.run_rev;
  assign decel_o = q.decel;
  assign homing_o = q.homing;
  assign torque_mode_o = q.torque;
  assign zero_current_o = q.zero_cur;
  assign hold_zero_speed_o = q.hold_zero;
  assign table_o = q.table_sel;
  assign fault_o = q.fault;
  assign ext_trip_o = q.ext_trip;
  assign irq_o = q.irq;

endmodule

// ===== hdl/bmd_pkg.sv
package bmd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DEBOUNCE_US = 5_000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // Parameter tables
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TABLES = 4;
  localparam logic [1:0] TABLE_ONE = 2'h0;
  localparam logic [1:0] TABLE_TWO = 2'h1;
  localparam logic [1:0] TABLE_THREE = 2'h2;
  localparam logic [1:0] TABLE_FOUR = 2'h3;
  localparam int unsigned PARAM_W = 16;
  localparam int unsigned MODE_W = 4;
  localparam int unsigned ACTIVE_TABLE_PARAM = 52;
  localparam int unsigned NUM_IN = 9;

  // ----------------------------------------------------------------
  // Operating mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_KEYPAD = 4'h0;
  localparam logic [3:0] MODE_BIPOLAR = 4'h1;
  localparam logic [3:0] MODE_PROCESS = 4'h2;
  localparam logic [3:0] MODE_NETWORK = 4'h3;
  localparam logic [3:0] MODE_RST = MODE_BIPOLAR;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_W = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK = 4'h3;
  localparam logic [3:0] REG_MODE = 4'h4;
  localparam logic [3:0] REG_PARAM = 4'h5;
  localparam logic [3:0] REG_ACT_TBL = 4'h6;

  // CTRL bits
  localparam int unsigned CTRL_EXT_TRIP_EN = 0;
  // IRQ bits
  localparam int unsigned IRQ_FAULT_CLR = 0;
  localparam int unsigned IRQ_EXT_TRIP = 1;
  localparam int unsigned IRQ_TBL_CHG = 2;
  localparam int unsigned IRQ_MODE_REJ = 3;
  localparam int unsigned IRQ_W = 4;

  // Input index order on the discrete input vector
  localparam int unsigned IN_ENABLE = 0;
  localparam int unsigned IN_FWD = 1;
  localparam int unsigned IN_REV = 2;
  localparam int unsigned IN_HOME = 3;
  localparam int unsigned IN_TORQUE = 4;
  localparam int unsigned IN_SEL0 = 5;
  localparam int unsigned IN_SEL1 = 6;
  localparam int unsigned IN_FRESET = 7;
  localparam int unsigned IN_TRIP = 8;

  typedef enum logic [1:0] {
    BMD_RUN_STOP,
    BMD_RUN_FWD,
    BMD_RUN_REV
  } bmd_dir_t;

endpackage

// ===== verif/bipolar_mode_input_decoder_tb_top.sv
`timescale 1ns/1ps
module bipolar_mode_input_decoder_tb_top;
  import bmd_pkg::*;
  localparam int unsigned DEB = 4;
  logic core_clk_i, rst_i, fwd_cmd, rev_cmd, fault_set, wr, rd, kick, home_done;
  logic power, run_f, run_r, decel, homing, torque, zc, hz, fault, trip, irq;
  logic [8:0] want, pins;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, d;
  logic [1:0] tbl;
  int n_fail, n_tests;
  logic [8:0] sw_v [5] = '{9'h107, 9'h105, 9'h105, 9'h101, 9'h100};
  logic [1:0] cmd_v [5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
  logic [3:0] ex_v [5] = '{4'hC, 4'h9, 4'hA, 4'h9, 4'h0};
  bmd_pins pins_u (.core_clk_i, .want_i(want), .kick_i(kick), .pins_o(pins));
  bmd_decoder #(.DEBOUNCE_CYCLES(DEB)) dut_u (.core_clk_i, .rst_i,
    .enable_i(pins[IN_ENABLE]), .fwd_perm_i(pins[IN_FWD]), .rev_perm_i(pins[IN_REV]),
    .home_i(pins[IN_HOME]), .torque_sel_i(pins[IN_TORQUE]), .table_sel0_i(pins[IN_SEL0]),
    .table_sel1_i(pins[IN_SEL1]), .fault_reset_i(pins[IN_FRESET]), .ext_trip_i(pins[IN_TRIP]),
    .fwd_cmd_i(fwd_cmd), .rev_cmd_i(rev_cmd), .home_done_i(home_done), .fault_set_i(fault_set),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .power_en_o(power), .run_fwd_o(run_f), .run_rev_o(run_r), .decel_o(decel),
    .homing_o(homing), .torque_mode_o(torque), .zero_current_o(zc), .hold_zero_speed_o(hz),
    .table_o(tbl), .fault_o(fault), .ext_trip_o(trip), .irq_o(irq));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [15:0] v);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Waits out sync and debounce before outputs are judged
  task automatic pins_to(input logic [8:0] w, input logic [1:0] c);
    @(posedge core_clk_i);
    want <= w;
    {fwd_cmd, rev_cmd} <= c;
    repeat (DEB + 12) @(posedge core_clk_i);
    #1;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge core_clk_i);
    n_fail++;
    $display("FAIL watchdog expected done seen hang");
    close_out();
  end
  initial begin
    {rst_i, want, kick, fwd_cmd, rev_cmd, fault_set, wr, rd} = {1'b1, 9'h100, 6'h00};
    {addr, wdata, home_done, n_fail, n_tests} = '0;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rreg(REG_MODE, d); chk("op_mode", d, 16'(MODE_RST));
    wreg(REG_IRQ_MASK, 16'h000F);
    for (int i = 0; i < 4; i++) begin
      pins_to(9'h100 | 9'(i << 5), 2'h0);
      chk("table", 16'(tbl), 16'(i));
      rreg(REG_ACT_TBL, d); chk("act_tbl", d, 16'(i));
      wreg(REG_ACT_TBL, 16'h0000);
      wreg(REG_PARAM, 16'h1000 + 16'(i));
    end
    wreg(REG_MODE, 16'(MODE_NETWORK));
    for (int i = 0; i < 4; i++) begin
      pins_to(9'h100 | 9'(i << 5), 2'h0);
      rreg(REG_PARAM, d); chk("param", d, 16'h1000 + 16'(i));
      rreg(REG_MODE, d); chk("mode_kept", d, 16'(MODE_NETWORK));
    end
    wreg(REG_MODE, 16'(MODE_BIPOLAR));
    $display("test tables done");
    for (int i = 0; i < 5; i++) begin
      pins_to(sw_v[i], cmd_v[i]);
      chk("drive", 16'({power, run_f, run_r, decel}), 16'(ex_v[i]));
      rreg(REG_STATUS, d); chk("status", d[3:0], {ex_v[i][0], ex_v[i][1], ex_v[i][2], ex_v[i][3]});
    end
    pins_to(9'h111, 2'h0); chk("torque", 16'({torque, zc, hz}), 16'h0006);
    // Both permissives closed and no command, so no decel masks the hold
    pins_to(9'h107, 2'h0); chk("speed", 16'({torque, zc, hz}), 16'h0001);
    // Homing needs the forward permissive closed
    pins_to(9'h10B, 2'h0); chk("homing", 16'(homing), 16'h0001);
    @(posedge core_clk_i) home_done <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1 chk("home_end", 16'(homing), 16'h0000);
    @(posedge core_clk_i) home_done <= 1'b0;
    wreg(REG_MODE, 16'h0002);
    rreg(REG_MODE, d); chk("mode_rej", d, 16'(MODE_BIPOLAR));
    rreg(REG_IRQ_STAT, d); chk("rej_irq", d & 16'h0008, 16'h0008);
    $display("test drive done");
    pins_to(9'h100, 2'h0);
    @(posedge core_clk_i) fault_set <= 1'b1;
    @(posedge core_clk_i) fault_set <= 1'b0;
    #1 chk("fault_set", 16'(fault), 16'h0001);
    @(posedge core_clk_i) kick <= 1'b1;
    @(posedge core_clk_i) kick <= 1'b0;
    pins_to(9'h100, 2'h0); chk("fault_clr", 16'(fault), 16'h0000);
    pins_to(9'h000, 2'h0); chk("trip_off", 16'(trip), 16'h0000);
    wreg(REG_CTRL, 16'h0001);
    pins_to(9'h000, 2'h0); chk("trip_on", 16'(trip), 16'h0001);
    pins_to(9'h100, 2'h0);
    rreg(REG_IRQ_STAT, d); chk("irq_stat", d & 16'h0003, 16'h0003);
    chk("irq_set", 16'(irq), 16'h0001);
    wreg(REG_IRQ_STAT, 16'h000F);
    rreg(REG_IRQ_STAT, d); chk("irq_clr", d, 16'h0000);
    chk("irq_pin", 16'(irq), 16'h0000);
    $display("test faults done");
    wreg(REG_MODE, 16'(MODE_KEYPAD));
    pins_to(9'h160, 2'h0); chk("frozen", 16'(tbl), 16'(TABLE_ONE));
    $display("test freeze done");
    close_out();
  end
endmodule

// ===== verif/bmd_checker.sv
`timescale 1ns/1ps
module bmd_checker
  import bmd_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = 4
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Pins and register port
  input wire logic enable_i,
  input wire logic fault_reset_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Drive outputs
  input wire logic power_en_o,
  input wire logic run_fwd_o,
  input wire logic run_rev_o,
  input wire logic decel_o,
  input wire logic homing_o,
  input wire logic torque_mode_o,
  input wire logic zero_current_o,
  input wire logic hold_zero_speed_o,
  input wire logic [1:0] table_o,
  input wire logic fault_o,
  input wire logic ext_trip_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] open_q;
  logic [7:0] frst_q;
  logic trip_en_q;
  wire logic [7:0] st = {fault_o, ext_trip_o, torque_mode_o, homing_o, decel_o, run_rev_o,
      run_fwd_o, power_en_o};
  // Saturating ages of pin states, so a long open or idle spell never wraps back under the bound
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      open_q <= 8'h00;
      frst_q <= 8'hff;
      trip_en_q <= 1'b0;
    end else begin
      open_q <= enable_i ? 8'h00 : open_q + 8'(open_q != 8'hff);
      frst_q <= fault_reset_i ? 8'h00 : frst_q + 8'(frst_q != 8'hff);
      if (reg_wr_i && reg_addr_i == REG_CTRL) begin
        trip_en_q <= reg_wdata_i[CTRL_EXT_TRIP_EN];
      end
    end
  end
  sequence s_rd(logic [3:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  a_status_read: assert property (s_rd(REG_STATUS) |=> reg_rdata_o[7:0] == $past(st))
    else $error("status read differs from outputs");
  a_table_read: assert property (s_rd(REG_ACT_TBL) |=> reg_rdata_o == {14'h0000, $past(table_o)})
    else $error("active table read wrong");
  a_read_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside read slot");
  a_coast_off: assert property (open_q > DEBOUNCE_CYCLES + 6 |-> !power_en_o && !run_fwd_o)
    else $error("power stage on with enable open");
  a_dir_excl: assert property (!(run_fwd_o && run_rev_o))
    else $error("both directions running");
  a_torque_stop: assert property (zero_current_o |-> torque_mode_o && !hold_zero_speed_o)
    else $error("zero current outside torque mode");
  a_speed_hold: assert property (hold_zero_speed_o |-> !torque_mode_o)
    else $error("speed hold in torque mode");
  a_fault_clear: assert property ($fell(fault_o) |-> frst_q < DEBOUNCE_CYCLES + 12)
    else $error("fault cleared without reset closure");
  a_trip_gate: assert property ($rose(ext_trip_o) |-> trip_en_q)
    else $error("trip raised while disabled");
endmodule
bind bmd_decoder bmd_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk_u (.core_clk_i, .rst_i,
  .enable_i, .fault_reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .power_en_o, .run_fwd_o, .run_rev_o, .decel_o, .homing_o, .torque_mode_o, .zero_current_o,
  .hold_zero_speed_o, .table_o, .fault_o, .ext_trip_o);

// ===== verif/bmd_pins.sv
`timescale 1ns/1ps
module bmd_pins (
  // Clock
  input wire logic core_clk_i,
  // Requested contacts, high closed
  input wire logic [8:0] want_i,
  input wire logic kick_i,
  // Contact levels
  output logic [8:0] pins_o
);
  logic [3:0] hold_q = 4'h0;
  initial pins_o = 9'h000;
  // Momentary reset closure, long enough to pass debounce
  always @(posedge core_clk_i) begin
    hold_q <= kick_i ? 4'h8 : hold_q - 4'(hold_q != 4'h0);
    pins_o <= want_i | {1'b0, hold_q != 4'h0, 7'h00};
  end
endmodule
